// ===== rtl/brd_order_parity.sv
// Transaction ordering queues and address parity checking of the bridge.
`timescale 1ns/100ps
`default_nettype none
`include "brd_consts.svh"

// Behaviour
// RQ1: Posted writes leave in their arrival order.
// RQ2: Delayed read waits for earlier posted writes.
// RQ3: Read completion waits for earlier posted writes.
// RQ4: Delayed write never passes earlier posted writes.
// RQ5: Posted writes pass delayed work; arbitration fair.
// RQ6: Requests keep order, may pass completions.
// RQ7: Completions keep order; write completions pass posted.
// RQ8: Order per direction; completion travels opposite way.
// RQ9: Software reads back after posted writes.
// RQ10: Received parity travels with forwarded data.
// RQ11: Address parity checked on both buses.
// RQ12: Primary parity error, response on: no claim.
// RQ13: Secondary parity error, response on: no claim.
// RQ14: Response off: decode and claim normally.
// RQ15: Primary error sets primary detected flag.
// RQ16: Secondary error sets secondary detected flag.
// RQ17: Primary error signals system error when enabled.
// RQ18: Secondary error signals system error when enabled.
// RQ19: Memory writes posted; others delayed with retry.
// RQ20: Posted acceptance never waits on delayed work.
// RQ21: Priority alternates after each completed transfer.
module brd_order_parity (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Avalon-MM register slave.
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Transactions offered as target, bit 0 downstream, bit 1 upstream.
  input  wire logic [1:0]  i_acc_valid,
  input  wire logic [7:0]  i_acc_cmd,
  input  wire logic [63:0] i_acc_data,
  input  wire logic [1:0]  i_acc_par,
  output logic      [1:0]  o_pw_ready,
  output logic      [1:0]  o_dr_ready,
  output logic      [1:0]  o_acc_retry,
  // Completions from the target bus, indexed by the request direction.
  input  wire logic [1:0]  i_dc_valid,
  input  wire logic [7:0]  i_dc_cmd,
  input  wire logic [63:0] i_dc_data,
  input  wire logic [1:0]  i_dc_par,
  output logic      [1:0]  o_dc_ready,
  // Master issue per direction.
  output logic      [1:0]  o_iss_valid,
  output logic      [3:0]  o_iss_src,
  output logic      [7:0]  o_iss_cmd,
  output logic      [63:0] o_iss_data,
  output logic      [1:0]  o_iss_par,
  input  wire logic [1:0]  i_iss_done,
  // Address phases, bit 0 primary, bit 1 secondary.
  input  wire logic [1:0]  i_adr_valid,
  input  wire logic [63:0] i_adr,
  input  wire logic [7:0]  i_adr_cbe,
  input  wire logic [1:0]  i_adr_par,
  input  wire logic [1:0]  i_adr_hit,
  output logic      [1:0]  o_claim,
  output logic             o_p_serr_n
);

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  // ========================================================
  // Helper functions.
  // Memory write and write-and-invalidate are posted.
  function automatic logic brd_is_posted(input logic [3:0] cmd);
    return (cmd == `BRD_CMD_MEMW) || (cmd == `BRD_CMD_MWI);
  endfunction : brd_is_posted

  // I/O and configuration writes are delayed writes.
  function automatic logic brd_is_dwrite(input logic [3:0] cmd);
    return (cmd == `BRD_CMD_IOW) || (cmd == `BRD_CMD_CFGW);
  endfunction : brd_is_dwrite

  // True while posted writes taken before the snapshot are unfinished.
  function automatic logic brd_blocked(input logic [7:0] snap, input logic [7:0] done);
    logic [7:0] diff;
    diff = snap - done;
    return (diff != 8'h00) && (diff <= `BRD_OUTSTAND);
  endfunction : brd_blocked

  // Even parity over address, command and parity bit.
  function automatic logic brd_par_err(input logic [31:0] a, input logic [3:0] c, input logic p);
    return ^{a, c, p};
  endfunction : brd_par_err

  // Pointer advance with wrap at the queue depth.
  function automatic logic [2:0] brd_wrap(input logic [2:0] ptr, input logic [2:0] depth);
    return (ptr == depth - 3'h1) ? 3'h0 : ptr + 3'h1;
  endfunction : brd_wrap

  // ========================================================
  // Queue plumbing, index [direction][queue].
  logic [44:0] q_in   [2][3];  // Entry offered to a queue.
  logic [44:0] q_head [2][3];  // Oldest entry of a queue.
  logic [2:0]  q_cnt  [2][3];  // Occupancy.
  logic        q_push [2][3];  // Entry written.
  logic        q_pop  [2][3];  // Head retired.
  logic        q_rdy  [2][3];  // Registered room flag.
  logic [2:0]  ctrl_q;         // Response and system error enables.
  logic [2:0]  stat_q;         // Sticky error flags.
  logic [2:0]  stat_d;         // Next flags.
  logic [2:0]  stat_set;       // Error events this cycle.
  logic [1:0]  ev_det;         // Address parity error per bus.
  logic [1:0]  ev_serr;        // Error that raises a system error.

  genvar gd, gq, gb;
  generate
    for (gd = 0; gd < 2; gd++) begin : g_dir
      localparam int R = 1 - gd;  // Direction of the matching request.
      brd_pkg::brd_iss_state_type st_q;  // Issue state.
      brd_pkg::brd_src_type src_q;       // Queue being issued.
      brd_pkg::brd_src_type pick_src;    // Queue chosen when idle.
      logic [44:0] ent_q;                // Entry being issued.
      logic        prio_q;               // One gives delayed work priority.
      logic [7:0]  pw_in_q;              // Posted writes taken.
      logic [7:0]  pw_out_q;             // Posted writes finished.
      logic        posted_w;             // Offered command is posted.
      logic        pw_el;                // Posted head may go.
      logic        dq_el;                // Request head may go.
      logic        cq_el;                // Completion head may go.
      logic        dly_el;               // Some delayed head may go.
      logic        pick_v;               // Something may be issued.
      logic        retry_q;              // Retry answer for delayed offer.

      assign posted_w = brd_is_posted(i_acc_cmd[4*gd +: 4]);  // see RQ19
      // A posted entry carries its own sequence number as snapshot.
      assign q_in[gd][0] = {i_acc_cmd[4*gd +: 4], pw_in_q, i_acc_par[gd], i_acc_data[32*gd +: 32]};  // see RQ10
      assign q_in[gd][1] = {i_acc_cmd[4*gd +: 4], pw_in_q, i_acc_par[gd], i_acc_data[32*gd +: 32]};
      // Completions join the queue opposite to their request.
      assign q_in[gd][2] = {i_dc_cmd[4*R +: 4], pw_in_q, i_dc_par[R], i_dc_data[32*R +: 32]};  // see RQ8
      // Posted acceptance looks only at posted room.
      assign q_push[gd][0] = i_acc_valid[gd] & posted_w & q_rdy[gd][0];  // see RQ20
      assign q_push[gd][1] = i_acc_valid[gd] & ~posted_w & q_rdy[gd][1];
      assign q_push[gd][2] = i_dc_valid[R] & q_rdy[gd][2];
      for (gq = 0; gq < 3; gq++) begin : g_pop
        assign q_pop[gd][gq] = (st_q == brd_pkg::BRD_BUSY) && i_iss_done[gd] && (src_q == gq);
      end

      // Eligibility of each head against earlier posted writes.
      assign pw_el = q_cnt[gd][0] != 3'h0;  // see RQ5
      assign dq_el = (q_cnt[gd][1] != 3'h0)
                     && !brd_blocked(q_head[gd][1][`BRD_E_SNAP], pw_out_q);  // see RQ2, RQ4
      assign cq_el = (q_cnt[gd][2] != 3'h0)
                     && (brd_is_dwrite(q_head[gd][2][`BRD_E_CMD])  // see RQ7
                         || !brd_blocked(q_head[gd][2][`BRD_E_SNAP], pw_out_q));  // see RQ3
      assign dly_el = dq_el | cq_el;
      assign pick_v = pw_el | dly_el;
      // Completions go before requests; posted and delayed take turns.
      assign pick_src = (pw_el && (!dly_el || !prio_q)) ? brd_pkg::BRD_SRC_PW :  // see RQ5
                        cq_el ? brd_pkg::BRD_SRC_CQ : brd_pkg::BRD_SRC_DQ;  // see RQ6, RQ7

      // Issue state machine and posted write counters.
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          st_q     <= brd_pkg::BRD_IDLE;
          src_q    <= brd_pkg::BRD_SRC_PW;
          ent_q    <= 45'h0;
          prio_q   <= 1'h0;
          pw_in_q  <= 8'h00;
          pw_out_q <= 8'h00;
          retry_q  <= 1'h0;
        end else begin
          retry_q <= i_acc_valid[gd] & ~posted_w;  // see RQ19
          if (q_push[gd][0]) begin
            pw_in_q <= pw_in_q + 8'h01;
          end
          if (q_pop[gd][0]) begin
            pw_out_q <= pw_out_q + 8'h01;
          end
          case (st_q)
            brd_pkg::BRD_IDLE: begin
              if (pick_v) begin
                st_q  <= brd_pkg::BRD_BUSY;
                src_q <= pick_src;
                ent_q <= q_head[gd][pick_src];  // see RQ1
              end
            end
            brd_pkg::BRD_BUSY: begin
              if (i_iss_done[gd]) begin
                st_q   <= brd_pkg::BRD_IDLE;
                prio_q <= (src_q == brd_pkg::BRD_SRC_PW);  // see RQ21
              end
            end
            default: st_q <= brd_pkg::BRD_IDLE;
          endcase
        end
      end

      assign o_iss_valid[gd]          = st_q;
      assign o_iss_src[2*gd +: 2]     = src_q;
      assign o_iss_cmd[4*gd +: 4]     = ent_q[`BRD_E_CMD];
      assign o_iss_data[32*gd +: 32]  = ent_q[`BRD_E_DATA];
      assign o_iss_par[gd]            = ent_q[`BRD_E_PAR];
      assign o_pw_ready[gd]           = q_rdy[gd][0];
      assign o_dr_ready[gd]           = q_rdy[gd][1];
      assign o_dc_ready[R]            = q_rdy[gd][2];
      assign o_acc_retry[gd]          = retry_q;

      // Each queue is a plain FIFO, so entries never pass within it.
      for (gq = 0; gq < 3; gq++) begin : g_q
        localparam logic [2:0] DEPTH = (gq == 0) ? `BRD_PW_DEPTH : `BRD_DT_DEPTH;
        logic [44:0] mem_q [`BRD_PW_DEPTH];  // Entry storage, sized for the deeper queue.
        logic [2:0]  wr_q;       // Write pointer.
        logic [2:0]  rd_q;       // Read pointer.
        logic [2:0]  cnt_q;      // Occupancy.
        logic [2:0]  cnt_d;      // Next occupancy.
        logic        rdy_q;      // Room for one more entry.

        assign cnt_d = cnt_q + {2'h0, q_push[gd][gq]} - {2'h0, q_pop[gd][gq]};

        // Storage has no reset; only written slots are ever read.
        always_ff @(posedge i_clk) begin
          if (q_push[gd][gq]) begin
            mem_q[wr_q] <= q_in[gd][gq];
          end
        end

        // Pointers and room flag.
        always_ff @(posedge i_clk or negedge i_arst_n) begin
          if (!i_arst_n) begin
            wr_q  <= 3'h0;
            rd_q  <= 3'h0;
            cnt_q <= 3'h0;
            rdy_q <= 1'h1;
          end else begin
            if (q_push[gd][gq]) begin
              wr_q <= brd_wrap(wr_q, DEPTH);  // see RQ1, RQ6, RQ7
            end
            if (q_pop[gd][gq]) begin
              rd_q <= brd_wrap(rd_q, DEPTH);
            end
            cnt_q <= cnt_d;
            rdy_q <= cnt_d != DEPTH;
          end
        end

        assign q_head[gd][gq] = mem_q[rd_q];
        assign q_cnt[gd][gq]  = cnt_q;
        assign q_rdy[gd][gq]  = rdy_q;
      end

      // Checks on issue order of this direction.
      sequence s_go(brd_pkg::brd_src_type s);
        (st_q == brd_pkg::BRD_IDLE) ##1 (st_q == brd_pkg::BRD_BUSY) && (src_q == s);
      endsequence
      AST_PW_ORDER: assert property (s_go(brd_pkg::BRD_SRC_PW) |-> ent_q[`BRD_E_SNAP] == pw_out_q) // see RQ1
        else $error("posted write issued out of order");
      AST_DRD_WAIT: assert property ((s_go(brd_pkg::BRD_SRC_DQ) ##0 !brd_is_dwrite(ent_q[`BRD_E_CMD]))
                                     |-> !brd_blocked(ent_q[`BRD_E_SNAP], pw_out_q)) // see RQ2
        else $error("delayed read passed posted write");
      AST_DWR_WAIT: assert property ((s_go(brd_pkg::BRD_SRC_DQ) ##0 brd_is_dwrite(ent_q[`BRD_E_CMD]))
                                     |-> !brd_blocked(ent_q[`BRD_E_SNAP], pw_out_q)) // see RQ4
        else $error("delayed write passed posted write");
      AST_RDC_WAIT: assert property ((s_go(brd_pkg::BRD_SRC_CQ) ##0 !brd_is_dwrite(ent_q[`BRD_E_CMD]))
                                     |-> !brd_blocked(ent_q[`BRD_E_SNAP], pw_out_q)) // see RQ3
        else $error("read completion passed posted write");
      AST_PW_ROOM: assert property ((q_cnt[gd][0] != `BRD_PW_DEPTH) |-> o_pw_ready[gd]) // see RQ20
        else $error("posted write refused with room");
      AST_FAIR: assert property ((st_q && i_iss_done[gd] && src_q == brd_pkg::BRD_SRC_PW)
                                 ##1 (pw_el && dly_el) |=> src_q != brd_pkg::BRD_SRC_PW) // see RQ21
        else $error("posted queue kept priority twice");
    end
  endgenerate

  // ========================================================
  // Address parity checking on both buses.
  generate
    for (gb = 0; gb < 2; gb++) begin : g_bus
      logic err_w;    // Parity error on this address phase.
      logic en_w;     // Parity error response enable.
      logic claim_q;  // Registered claim select.

      assign err_w = brd_par_err(i_adr[32*gb +: 32], i_adr_cbe[4*gb +: 4], i_adr_par[gb]);  // see RQ11
      assign en_w  = (gb == 0) ? ctrl_q[`BRD_CTRL_PPERR] : ctrl_q[`BRD_CTRL_SPERR];
      assign ev_det[gb]  = i_adr_valid[gb] & err_w;  // see RQ15, RQ16
      assign ev_serr[gb] = ev_det[gb] & en_w & ctrl_q[`BRD_CTRL_SERR];  // see RQ17, RQ18

      // Claim follows decode unless the error is being answered.
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          claim_q <= 1'h0;
        end else begin
          claim_q <= i_adr_valid[gb] & i_adr_hit[gb] & ~(err_w & en_w);  // see RQ12, RQ13, RQ14
        end
      end
      assign o_claim[gb] = claim_q;

      sequence s_err;
        i_adr_valid[gb] && err_w;
      endsequence
      AST_NO_CLAIM: assert property ((s_err ##0 en_w) |=> !o_claim[gb]) // see RQ12, RQ13
        else $error("claimed despite address parity error");
      AST_CLAIM_ON: assert property ((i_adr_valid[gb] && i_adr_hit[gb] && !en_w) |=> o_claim[gb]) // see RQ14
        else $error("no claim with response disabled");
      AST_DET_FLAG: assert property (s_err |=> stat_q[(gb == 0) ? `BRD_STAT_PDET : `BRD_STAT_SDET]) // see RQ15, RQ16
        else $error("detected parity flag not set");
      AST_SERR: assert property ((s_err ##0 en_w ##0 ctrl_q[`BRD_CTRL_SERR])
                                 |=> !o_p_serr_n && stat_q[`BRD_STAT_PSIG]) // see RQ17, RQ18
        else $error("system error not signalled");
    end
  endgenerate

  // ========================================================
  // Error flags and the primary system error output.
  assign stat_set[`BRD_STAT_PDET] = ev_det[0];
  assign stat_set[`BRD_STAT_SDET] = ev_det[1];
  assign stat_set[`BRD_STAT_PSIG] = |ev_serr;

  // ========================================================
  // Avalon-MM slave with one wait cycle per access.
  logic        wait_q;    // Registered waitrequest.
  logic [31:0] rdata_q;   // Registered read data.
  logic        req_w;     // Access pending.
  logic        take_w;    // Access completes at this edge.
  logic        wr_ctrl;   // Control register write.
  logic        wr_stat;   // Status register clear.
  logic [31:0] rdata_w;   // Read data mux.

  assign req_w   = i_avs_read | i_avs_write;
  assign take_w  = req_w & ~wait_q;
  assign wr_ctrl = take_w & i_avs_write & i_avs_byteenable[0] & (i_avs_address == `BRD_OFS_CTRL);
  assign wr_stat = take_w & i_avs_write & i_avs_byteenable[0] & (i_avs_address == `BRD_OFS_STAT);
  // A flag raised in the clearing cycle survives the clear.
  assign stat_d  = (stat_q & ~(wr_stat ? i_avs_writedata[2:0] : 3'h0)) | stat_set;
  // Unmapped addresses read zero and ignore writes.
  assign rdata_w = (i_avs_address == `BRD_OFS_CTRL) ? {29'h0, ctrl_q} :
                   (i_avs_address == `BRD_OFS_STAT) ? {29'h0, stat_q} :
                   (i_avs_address == `BRD_OFS_QOCC) ? {14'h0, q_cnt[1][2], q_cnt[1][1], q_cnt[1][0],
                                                       q_cnt[0][2], q_cnt[0][1], q_cnt[0][0]} : 32'h0;

  // Bus handshake, registers and system error pulse.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_q     <= 1'h1;
      rdata_q    <= 32'h0;
      ctrl_q     <= `BRD_CTRL_RST;
      stat_q     <= `BRD_STAT_RST;
      o_p_serr_n <= 1'h1;
    end else begin
      wait_q     <= ~(req_w & wait_q);
      rdata_q    <= (req_w & wait_q) ? rdata_w : rdata_q;
      ctrl_q     <= wr_ctrl ? i_avs_writedata[2:0] : ctrl_q;
      stat_q     <= stat_d;  // see RQ15, RQ16, RQ17, RQ18
      o_p_serr_n <= ~(|ev_serr);  // see RQ17, RQ18
    end
  end

  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata    = rdata_q;

endmodule : brd_order_parity
`default_nettype wire

// ===== rtl/brd_consts.svh
// Constants for the bridge ordering and address parity block.
`ifndef BRD_CONSTS_SVH
`define BRD_CONSTS_SVH
// ==========================================================
// Register map, byte addresses on the Avalon-MM slave.
`define BRD_OFS_CTRL 4'h0
`define BRD_OFS_STAT 4'h4
`define BRD_OFS_QOCC 4'h8
// Control register bits and reset value.
`define BRD_CTRL_PPERR 0
`define BRD_CTRL_SERR 1
`define BRD_CTRL_SPERR 2
`define BRD_CTRL_RST 3'h0
// Status register bits, write one to clear.
`define BRD_STAT_PDET 0
`define BRD_STAT_PSIG 1
`define BRD_STAT_SDET 2
`define BRD_STAT_RST 3'h0
// ==========================================================
// Bus commands that the ordering logic must recognise.
`define BRD_CMD_IOW 4'h3
`define BRD_CMD_MEMW 4'h7
`define BRD_CMD_CFGW 4'hb
`define BRD_CMD_MWI 4'hf
// Queue depths and the most posted writes outstanding.
`define BRD_PW_DEPTH 3'h5
`define BRD_DT_DEPTH 3'h3
`define BRD_OUTSTAND 8'h05
// Queue entry layout.
`define BRD_E_DATA 31:0
`define BRD_E_PAR 32
`define BRD_E_SNAP 40:33
`define BRD_E_CMD 44:41
`endif

// ===== rtl/brd_pkg.sv
// Types shared by the bridge ordering and address parity block.
package brd_pkg;
  // ========================================================
  // Queue that an issued transfer comes from.
  typedef enum logic [1:0] {
    BRD_SRC_PW = 2'b00,
    BRD_SRC_DQ = 2'b01,
    BRD_SRC_CQ = 2'b10
  } brd_src_type;
  // Master issue state of one direction.
  typedef enum logic {
    BRD_IDLE = 1'b0,
    BRD_BUSY = 1'b1
  } brd_iss_state_type;
endpackage : brd_pkg

// ===== testbench/brd_far_tgt.sv
// Destination bus target model that finishes issued transfers after a set delay.
`timescale 1ns/100ps
`default_nettype none
module brd_far_tgt #(
  parameter int DLY = 2  // Cycles counted on a transfer; done rises DLY+1 cycles after valid.
) (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Issue handshake per direction.
  input  wire logic [1:0] i_iss_valid,
  output var  logic [1:0] o_iss_done
);
  logic [7:0] cnt_q [2];  // Cycles spent on the current transfer.
  // ==========================================================
  // Finish handshake
  // A zero delay answers promptly; a larger one stalls the bridge master.
  // The counter restarts on done, because valid stays up one more cycle.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_iss_done <= 2'h0;
      cnt_q      <= '{8'h00, 8'h00};
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (o_iss_done[d] || !i_iss_valid[d]) begin
          o_iss_done[d] <= 1'b0;
          cnt_q[d]      <= 8'h00;
        end else begin
          o_iss_done[d] <= (cnt_q[d] >= DLY);
          cnt_q[d]      <= cnt_q[d] + 8'h01;
        end
      end
    end
  end
endmodule : brd_far_tgt
`default_nettype wire

// ===== testbench/bridge_order_addr_parity_tb.sv
// Self-checking bench for the bridge ordering and address parity block.
`timescale 1ns/100ps
`default_nettype none
`include "brd_consts.svh"
module bridge_order_addr_parity_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic        i_clk = 1'b0;     // Bench clock, 10 MHz.
  logic        i_arst_n = 1'b0;  // Reset, active low.
  logic [3:0]  av_addr = 4'h0;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic [1:0]  acc_v = 2'h0;
  logic [7:0]  acc_cmd = 8'h00;
  logic [63:0] acc_dat = 64'h0;
  logic [1:0]  acc_par = 2'h0;
  logic [1:0]  pw_rdy, dr_rdy, retry, dc_rdy, iss_v, iss_par, iss_done, claim;
  logic [3:0]  iss_src;
  logic [7:0]  iss_cmd;
  logic [63:0] iss_dat;
  logic        serr_n;
  logic [1:0]  adr_v = 2'h0;
  logic [63:0] adr = {32'h1, 32'h1};  // One set bit per bus.
  logic [7:0]  cbe = 8'h77;           // Three set bits per bus, so parity 0 is good.
  logic [1:0]  adr_par = 2'h0;
  logic [1:0]  adr_hit = 2'h3;        // Decode hit per bus.
  logic [3:0]  av_be = 4'hf;          // Avalon byte enables.
  logic [1:0]  dc_v = 2'h0;           // Completion valid, by request direction.
  logic [7:0]  dc_cmd = 8'h00;
  logic [63:0] dc_dat = 64'h0;
  logic [1:0]  dc_par = 2'h0;
  int          num_errors = 0;
  int          checked = 0;
  int          retries = 0;  // Retry pulses seen downstream.
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (retry[0] === 1'b1) retries++;
  end
  // ==========================================================
  // Design and far side
  brd_order_parity brd_order_parity_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(av_addr), .i_avs_read(av_rd),
    .i_avs_write(av_wr), .i_avs_writedata(av_wd), .i_avs_byteenable(av_be),
    .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .i_acc_valid(acc_v),
    .i_acc_cmd(acc_cmd), .i_acc_data(acc_dat), .i_acc_par(acc_par), .o_pw_ready(pw_rdy),
    .o_dr_ready(dr_rdy), .o_acc_retry(retry), .i_dc_valid(dc_v), .i_dc_cmd(dc_cmd),
    .i_dc_data(dc_dat), .i_dc_par(dc_par), .o_dc_ready(dc_rdy), .o_iss_valid(iss_v),
    .o_iss_src(iss_src), .o_iss_cmd(iss_cmd), .o_iss_data(iss_dat), .o_iss_par(iss_par),
    .i_iss_done(iss_done), .i_adr_valid(adr_v), .i_adr(adr), .i_adr_cbe(cbe),
    .i_adr_par(adr_par), .i_adr_hit(adr_hit), .o_claim(claim), .o_p_serr_n(serr_n));
  brd_far_tgt #(.DLY(3)) brd_far_tgt_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_iss_valid(iss_v), .o_iss_done(iss_done));
  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One Avalon access; the request is held until waitrequest is sampled low.
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge i_clk);
    av_addr <= a;
    av_wd   <= d;
    av_rd   <= !wr;
    av_wr   <= wr;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      if (av_wait === 1'b0) break;
    end
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    if (n == 20) begin
      num_errors++;
      summarize();
    end
  endtask : av
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask : wr
  // One address phase on a bus; claim and system error are looked at a cycle later.
  task automatic adr_phase(input int b, input logic bad, input logic exp_claim, input logic exp_serr_n);
    @(posedge i_clk);
    adr_v   <= 2'h1 << b;
    adr_par <= {bad, bad};
    @(posedge i_clk);
    adr_v <= 2'h0;
    @(posedge i_clk);
    check("claim", {31'h0, exp_claim}, {31'h0, claim[b]});
    check("serr_n", {31'h0, exp_serr_n}, {31'h0, serr_n});
  endtask : adr_phase
  // Waits for the next finished downstream transfer and compares it.
  task automatic take(input logic [1:0] src, input logic [3:0] c, input logic [31:0] d, input logic p);
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (iss_v[0] === 1'b1 && iss_done[0] === 1'b1) break;
    end
    if (n == 50) begin
      num_errors++;
      summarize();
    end
    check("iss_src", {30'h0, src}, {30'h0, iss_src[1:0]});
    check("iss_cmd", {28'h0, c}, {28'h0, iss_cmd[3:0]});
    check("iss_data", d, iss_dat[31:0]);
    check("iss_par", {31'h0, p}, {31'h0, iss_par[0]});
  endtask : take
  // ==========================================================
  // Test sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(`BRD_OFS_CTRL, 32'h0, "ctrl reset");
    rd(`BRD_OFS_STAT, 32'h0, "stat reset");
    rd(4'hc, 32'h0, "unmapped");
    // A write without its low byte enable must leave the control bits alone.
    av_be <= 4'he;
    wr(`BRD_OFS_CTRL, 32'h7);
    av_be <= 4'hf;
    rd(`BRD_OFS_CTRL, 32'h0, "ctrl masked");
    $display("test registers done");
    wr(`BRD_OFS_CTRL, 32'h3);
    adr_phase(0, 1'b1, 1'b0, 1'b0);
    rd(`BRD_OFS_STAT, 32'h3, "stat primary");
    wr(`BRD_OFS_STAT, 32'h7);
    rd(`BRD_OFS_STAT, 32'h0, "stat cleared");
    adr_phase(0, 1'b0, 1'b1, 1'b1);
    adr_hit <= 2'h2;
    adr_phase(0, 1'b0, 1'b0, 1'b1);
    adr_hit <= 2'h3;
    wr(`BRD_OFS_CTRL, 32'h0);
    adr_phase(0, 1'b1, 1'b1, 1'b1);
    rd(`BRD_OFS_STAT, 32'h1, "stat no serr");
    wr(`BRD_OFS_STAT, 32'h7);
    wr(`BRD_OFS_CTRL, 32'h6);
    adr_phase(1, 1'b1, 1'b0, 1'b0);
    rd(`BRD_OFS_STAT, 32'h6, "stat secondary");
    $display("test address parity done");
    // Posted A, delayed read D, posted B, delayed write W back to back downstream.
    // Read completion R joins the downstream queue with W, so it must wait for B.
    @(posedge i_clk);
    acc_v   <= 2'h1;
    acc_cmd <= {4'h0, `BRD_CMD_MEMW};
    acc_dat <= 64'h000000a1;
    acc_par <= 2'h1;
    @(posedge i_clk);
    acc_cmd <= 8'h06;
    acc_dat <= 64'h000000d2;
    acc_par <= 2'h0;
    @(posedge i_clk);
    acc_cmd <= {4'h0, `BRD_CMD_MWI};
    acc_dat <= 64'h000000b3;
    acc_par <= 2'h1;
    @(posedge i_clk);
    acc_cmd <= {4'h0, `BRD_CMD_IOW};
    acc_dat <= 64'h000000e5;
    acc_par <= 2'h0;
    dc_v    <= 2'h2;
    dc_cmd  <= 8'h60;
    dc_dat  <= {32'hc4, 32'h0};
    dc_par  <= 2'h2;
    @(posedge i_clk);
    acc_v <= 2'h0;
    dc_v  <= 2'h0;
    take(2'h0, `BRD_CMD_MEMW, 32'ha1, 1'b1);
    rd(`BRD_OFS_QOCC, 32'h51, "qocc after first");
    take(2'h1, 4'h6, 32'hd2, 1'b0);
    take(2'h0, `BRD_CMD_MWI, 32'hb3, 1'b1);
    take(2'h2, 4'h6, 32'hc4, 1'b1);
    take(2'h1, `BRD_CMD_IOW, 32'he5, 1'b0);
    rd(`BRD_OFS_QOCC, 32'h0, "qocc drained");
    check("retries", 32'h2, retries);
    $display("test ordering done");
    summarize();
  end
endmodule : bridge_order_addr_parity_tb
`default_nettype wire
